// ==== irq_standby_serial_unit.sv ====
// interrupt controller, standby control and 8-bit clocked serial shifter
`timescale 1ns/100ps
module irq_standby_serial_unit
    import irq_standby_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     serialClkN,
    input  wire logic                     serialIn,
    output logic                          serialOut,
    input  wire logic                     timerMatch,
    input  wire logic                     sharedPinZero,
    input  wire logic                     extIrqOne,
    input  wire logic [3:0]               shiftModeWr,
    input  wire logic                     shiftModeWe,
    input  wire logic [2:0]               enableWr,
    input  wire logic                     enableWe,
    input  wire logic                     gateOpenOp,
    input  wire logic                     gateCloseOp,
    input  wire logic                     skipOnFlagOp,
    input  wire logic [1:0]               skipSel,
    input  wire logic                     stopOp,
    input  wire logic                     haltOp,
    input  wire logic                     cpuReady,
    input  wire logic                     rcClockIn,
    input  wire logic                     rxReady,
    output irq_standby_pkg::irq_ack_t     irqAck,
    output irq_standby_pkg::byte_t        rxByte,
    output logic [2:0]                    requestFlags,
    output logic                          masterIrqGate,
    output logic [2:0]                    sourceEnableField,
    output logic [3:0]                    shiftModeBits,
    output logic                          skipTaken,
    output logic                          cpuClockEn,
    output logic                          rcClockOut,
    output logic                          standbyStop,
    output logic                          standbyHalt
);
    import irq_standby_pkg::*;

    // two-flop synchronisers for the serial and event pins; only stage two is read
    logic [4:0] syncA_q, syncB_q;
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            // serial clock and data idle high, event pins idle low: no false edge after reset
            syncA_q <= 5'h18;
            syncB_q <= 5'h18;
        end
        else
        begin
            syncA_q <= {serialClkN, serialIn, timerMatch, sharedPinZero, extIrqOne};
            syncB_q <= syncA_q;
        end
    logic sckS, siS, tmS, p0S, e1S;
    assign {sckS, siS, tmS, p0S, e1S} = syncB_q;

    // edge detectors on synchronised levels
    logic sckOld_q, tmOld_q, p0Old_q, e1Old_q;
    logic sckFall, sckRise, tmEv, p0Ev, e1Ev;
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            sckOld_q <= 1'b1;
            tmOld_q  <= 1'b0;
            p0Old_q  <= 1'b0;
            e1Old_q  <= 1'b0;
        end
        else
        begin
            sckOld_q <= sckS;
            tmOld_q  <= tmS;
            p0Old_q  <= p0S;
            e1Old_q  <= e1S;
        end
    assign sckFall = sckOld_q & ~sckS;
    assign sckRise = ~sckOld_q & sckS;
    assign tmEv    = tmS & ~tmOld_q;
    assign p0Ev    = p0S & ~p0Old_q;  // rising edge of shared pin
    assign e1Ev    = e1S & ~e1Old_q;

    // serial shifter state
    logic [7:0] shift_q, shift_d;
    logic [2:0] bitCnt_q, bitCnt_d;
    logic [3:0] mode_q, mode_d;
    logic       so_q, so_d;
    logic       byteDone;
    logic       shiftRun;
    assign shiftRun = mode_q[SM_RUN_BIT];

    always_comb
    begin
        shift_d  = shift_q;
        bitCnt_d = bitCnt_q;
        so_d     = so_q;
        byteDone = 1'b0;
        mode_d   = shiftModeWe ? shiftModeWr : mode_q;
        // shifter runs in standby too; only the mode bits gate it
        if (shiftRun && sckFall)
            so_d = shift_q[SHIFT_W-1];
        if (shiftRun && sckRise)
        begin
            shift_d  = {shift_q[SHIFT_W-2:0], siS};
            bitCnt_d = bitCnt_q + 3'h1;
            byteDone = (bitCnt_q == BIT_CNT_LAST);
        end
        if (!shiftRun)
            bitCnt_d = 3'h0;
    end

    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            shift_q  <= 8'h00;
            bitCnt_q <= 3'h0;
            so_q     <= 1'b1;
            mode_q   <= SM_RESET;
        end
        else
        begin
            shift_q  <= shift_d;
            bitCnt_q <= bitCnt_d;
            so_q     <= so_d;
            mode_q   <= mode_d;
        end

    // two-entry receive buffer so a stalled reader loses no completed byte until both entries are full
    logic [7:0] buf_q [2], buf_d [2];
    logic [1:0] bufCnt_q, bufCnt_d;
    logic       bufReady;
    logic       pop;
    assign bufReady = (bufCnt_q != 2'h2);
    assign pop      = (bufCnt_q != 2'h0) && rxReady;
    always_comb
    begin
        buf_d    = buf_q;
        bufCnt_d = bufCnt_q;
        if (pop)
        begin
            buf_d[0] = buf_q[1];
            bufCnt_d = bufCnt_d - 2'h1;
        end
        // a byte arriving with the buffer full is dropped unless a pop frees an entry in the same cycle
        if (byteDone && (bufReady || pop))
        begin
            buf_d[bufCnt_d[0]] = shift_d;
            bufCnt_d = bufCnt_d + 2'h1;
        end
    end
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            buf_q[0] <= 8'h00;
            buf_q[1] <= 8'h00;
            bufCnt_q <= 2'h0;
        end
        else
        begin
            buf_q    <= buf_d;
            bufCnt_q <= bufCnt_d;
        end

    // interrupt controller state
    logic [2:0] rqf_q, rqf_d;
    logic [2:0] ie_q, ie_d;
    logic       ime_q, ime_d;
    logic       ackV_q, ackV_d;
    logic [7:0] ackVec_q, ackVec_d;
    logic       skip_q, skip_d;
    logic [2:0] events, live, clr;
    logic       sharedEv;

    always_comb
    begin
        // pin or serial done feeds the shared source, same vector either way
        sharedEv = mode_q[SM_PIN_BIT] ? p0Ev : byteDone;
        events   = 3'h0;
        events[SRC_TIMER]   = tmEv;
        events[SRC_SHARED]  = sharedEv;
        events[SRC_EXT_ONE] = e1Ev;
        live     = rqf_q & ie_q;
        clr      = 3'h0;
        ackV_d   = 1'b0;
        ackVec_d = VEC_NONE;
        ime_d    = ime_q;
        ie_d     = enableWe ? enableWr : ie_q;
        skip_d   = 1'b0;
        if (gateOpenOp)
            ime_d = 1'b1;
        if (gateCloseOp)
            ime_d = 1'b0;
        // fixed priority: timer, then shared, then ext one
        if (ime_q && cpuReady && (live != 3'h0))
        begin
            ackV_d = 1'b1;
            ime_d  = 1'b0;
            if (live[SRC_TIMER])
            begin
                ackVec_d = VEC_TIMER;
                clr[SRC_TIMER] = 1'b1;
            end
            else if (live[SRC_SHARED])
            begin
                ackVec_d = VEC_SHARED;
                clr[SRC_SHARED] = 1'b1;
            end
            else
            begin
                ackVec_d = VEC_EXT_ONE;
                clr[SRC_EXT_ONE] = 1'b1;
            end
        end
        if (skipOnFlagOp && skipSel != 2'h3)
        begin
            skip_d = rqf_q[skipSel];
            clr[skipSel] = 1'b1;
        end
        // a new event in the clearing cycle wins over the clear
        rqf_d = (rqf_q & ~clr) | events;
    end

    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            rqf_q    <= 3'h0;
            ie_q     <= IE_RESET;
            ime_q    <= 1'b0;
            ackV_q   <= 1'b0;
            ackVec_q <= VEC_NONE;
            skip_q   <= 1'b0;
        end
        else
        begin
            rqf_q    <= rqf_d;
            ie_q     <= ie_d;
            ime_q    <= ime_d;
            ackV_q   <= ackV_d;
            ackVec_q <= ackVec_d;
            skip_q   <= skip_d;
        end

    // standby control
    power_t pwr_q, pwr_d;
    logic   rcOut_q, rcOut_d;
    logic   cpuEn_q, cpuEn_d;
    logic   cpuDiv_q, cpuDiv_d;
    always_comb
    begin
        pwr_d = pwr_q;
        case (pwr_q)
            RUN:
                if (rqf_q == 3'h0)
                begin
                    if (stopOp)
                        pwr_d = STOP;
                    else if (haltOp)
                        pwr_d = HALT;
                end
            STOP:
                if (rqf_q[SRC_TIMER] || rqf_q[SRC_SHARED])
                    pwr_d = RUN;
            HALT:
                if (rqf_q != 3'h0)
                    pwr_d = RUN;
            default:
                pwr_d = RUN;
        endcase
        // half-rate cpu clock enable pulses only while running
        cpuDiv_d = (pwr_q == RUN) ? ~cpuDiv_q : cpuDiv_q;
        cpuEn_d  = (pwr_q == RUN) && cpuDiv_q;
        rcOut_d  = (pwr_q == STOP) ? 1'b0 : rcClockIn;
    end
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            pwr_q    <= RUN;
            rcOut_q  <= 1'b0;
            cpuEn_q  <= 1'b0;
            cpuDiv_q <= 1'b0;
        end
        else
        begin
            pwr_q    <= pwr_d;
            rcOut_q  <= rcOut_d;
            cpuEn_q  <= cpuEn_d;
            cpuDiv_q <= cpuDiv_d;
        end

    // outputs, all from flip-flops
    assign serialOut         = so_q;
    assign irqAck.valid      = ackV_q;
    assign irqAck.vector     = ackVec_q;
    assign rxByte.valid      = (bufCnt_q != 2'h0);
    assign rxByte.data       = buf_q[0];
    assign requestFlags      = rqf_q;
    assign masterIrqGate     = ime_q;
    assign sourceEnableField = ie_q;
    assign shiftModeBits     = mode_q;
    assign skipTaken         = skip_q;
    assign cpuClockEn        = cpuEn_q;
    assign rcClockOut        = rcOut_q;
    assign standbyStop       = (pwr_q == STOP);
    assign standbyHalt       = (pwr_q == HALT);
endmodule

// ==== irq_standby_pkg.sv ====
// shared types and constants for the interrupt, standby and serial block
// Functional notes
// - on each serial clock falling edge, drive shift register bit 7 onto serial out.
// - on following rising edge, shift toward MSB and capture serial in into LSB.
// - 3-bit counter counts clocks; every eighth raises serial done, sets shared flag.
// - timer vector 10H priority 1, shared 20H priority 2, ext one 30H priority 3.
// - shift mode selects serial done or shared pin as shared source; same vector.
// - three enable bits: timer, shared, ext one; 1 passes request, 0 blocks.
// - master gate clears automatically whenever an interrupt is accepted.
// - gate open sets master gate, gate close clears it; enable field untouched.
// - stop and halt standby modes, each entered by its own instruction.
// - in standby execution stops, state retained; serial and timer keep running.
// - standby exits on reset or on an interrupt request; ext one releases halt but not stop.
// - stop or halt has no effect while any request flag is set.
// - stop halts rc clock output; halt keeps it; both stop cpu clock.
// - stop released by timer or shared source; halt also by ext one.
// - reset clears request flags, master gate, enable field, pending interrupt.
// - reset clears shift mode bits, stops shifting, selects serial done source.
package irq_standby_pkg;
    localparam int          SHIFT_W      = 8;
    localparam int          MODE_W       = 4;
    localparam logic [2:0]  BIT_CNT_LAST = 3'h7;
    localparam logic [7:0]  VEC_TIMER    = 8'h10;
    localparam logic [7:0]  VEC_SHARED   = 8'h20;
    localparam logic [7:0]  VEC_EXT_ONE  = 8'h30;
    localparam logic [7:0]  VEC_NONE     = 8'h00;
    // shift mode bit positions: bit 3 enables shifting, bit 0 picks pin as shared source
    localparam int          SM_RUN_BIT   = 3;
    localparam int          SM_PIN_BIT   = 0;
    localparam logic [3:0]  SM_RESET     = 4'h0;
    localparam logic [2:0]  IE_RESET     = 3'h0;
    // enable / flag bit positions
    localparam int          SRC_TIMER    = 0;
    localparam int          SRC_SHARED   = 1;
    localparam int          SRC_EXT_ONE  = 2;

    typedef enum logic [1:0] {RUN, STOP, HALT} power_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] vector;
    } irq_ack_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_t;
endpackage

// ==== irq_standby_serial_unit_asserts.sv ====
// checker for gate, priority and standby behaviour
`timescale 1ns/100ps
module irq_standby_serial_unit_asserts
    import irq_standby_pkg::*;
(
    input wire logic                      clk,
    input wire logic                      nrst,
    input wire logic                      gateOpenOp,
    input wire logic                      gateCloseOp,
    input wire logic                      stopOp,
    input wire logic                      haltOp,
    input wire logic                      cpuReady,
    input wire irq_standby_pkg::irq_ack_t irqAck,
    input wire logic [2:0]                requestFlags,
    input wire logic                      masterIrqGate,
    input wire logic [2:0]                sourceEnableField,
    input wire logic                      standbyStop,
    input wire logic                      standbyHalt,
    input wire logic                      cpuClockEn,
    input wire logic                      rcClockOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // two standby cycles, so registered clock outputs have settled
    sequence s_idle2;
        (standbyStop || standbyHalt) [*2];
    endsequence
    property p_ackGate;
        irqAck.valid |-> !masterIrqGate && $past(masterIrqGate) && $past(cpuReady);
    endproperty
    a_ackGate: assert property (p_ackGate) else $error("ack without open gate");
    property p_ackVec;
        irqAck.valid |-> irqAck.vector == ($past(requestFlags[0] && sourceEnableField[0]) ? VEC_TIMER :
            $past(requestFlags[1] && sourceEnableField[1]) ? VEC_SHARED : VEC_EXT_ONE);
    endproperty
    a_ackVec: assert property (p_ackVec) else $error("wrong vector");
    property p_gateOpen;
        // an acceptance in the same cycle closes the gate again
        gateOpenOp && !gateCloseOp |=> masterIrqGate || irqAck.valid;
    endproperty
    a_gateOpen: assert property (p_gateOpen) else $error("gate not opened");
    property p_gateClose;
        gateCloseOp |=> !masterIrqGate;
    endproperty
    a_gateClose: assert property (p_gateClose) else $error("gate not closed");
    property p_noStandby;
        (stopOp || haltOp) && requestFlags != 3'h0 && !standbyStop && !standbyHalt |=> !standbyStop && !standbyHalt;
    endproperty
    a_noStandby: assert property (p_noStandby) else $error("standby with pending flag");
    property p_stopExt;
        standbyStop && requestFlags == 3'h4 |=> standbyStop || requestFlags[1:0] != 2'h0;
    endproperty
    a_stopExt: assert property (p_stopExt) else $error("stop left on ext one");
    property p_haltExit;
        standbyHalt && requestFlags != 3'h0 |-> ##[0:2] !standbyHalt;
    endproperty
    a_haltExit: assert property (p_haltExit) else $error("halt kept with flag");
    property p_clkStop;
        s_idle2 |-> !cpuClockEn && !(standbyStop && rcClockOut);
    endproperty
    a_clkStop: assert property (p_clkStop) else $error("clock runs in standby");
endmodule

// ==== serial_peer_model.sv ====
// far-side serial peer: clocks one byte, msb first
`timescale 1ns/100ps
module serial_peer_model
(
    output logic      serialClkN,
    output logic      serialIn,
    input  wire logic serialOut
);
    // clock stands high outside frames
    initial
    begin
        serialClkN = 1'b1;
        serialIn   = 1'b0;
    end
    // sample late in the high phase, since the device output lags by its synchroniser
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            serialClkN = 1'b0;
            serialIn   = tx[i];
            #80;
            serialClkN = 1'b1;
            #80;
            rx[i] = serialOut;
        end
        serialIn = ~serialIn; // released line shows no stale bit
    endtask
endmodule

// ==== irq_standby_serial_unit_tb.sv ====
// self-checking bench for the interrupt, standby and serial unit
`timescale 1ns/100ps
module irq_standby_serial_unit_tb;
    import irq_standby_pkg::*;
    logic       clk, nrst, serialClkN, serialIn, serialOut, timerMatch, sharedPinZero, extIrqOne;
    logic       shiftModeWe, enableWe, gateOpenOp, gateCloseOp, skipOnFlagOp, stopOp, haltOp;
    logic       cpuReady, rcClockIn, rxReady, masterIrqGate, skipTaken, cpuClockEn, rcClockOut;
    logic       standbyStop, standbyHalt;
    logic [3:0] shiftModeWr, shiftModeBits, arg;
    logic [2:0] enableWr, requestFlags, sourceEnableField, pins;
    logic [1:0] skipSel;
    logic [6:0] ops;
    logic [7:0] rx;
    irq_ack_t   irqAck;
    byte_t      rxByte;
    int         miscompares, checkCount;
    localparam logic [6:0] WM = 7'h40, WE = 7'h20, OPEN = 7'h10, CLOSE = 7'h08, SKIP = 7'h04, STOP = 7'h02;
    localparam logic [6:0] HALT = 7'h01;

    // strobes and pins from the op and event tasks
    assign {shiftModeWe, enableWe, gateOpenOp, gateCloseOp, skipOnFlagOp, stopOp, haltOp} = ops;
    assign {shiftModeWr, enableWr, skipSel} = {arg, arg[2:0], arg[1:0]};
    assign {extIrqOne, sharedPinZero, timerMatch} = pins;

    irq_standby_serial_unit uut (.clk, .nrst, .serialClkN, .serialIn, .serialOut, .timerMatch, .sharedPinZero,
        .extIrqOne, .shiftModeWr, .shiftModeWe, .enableWr, .enableWe, .gateOpenOp, .gateCloseOp, .skipOnFlagOp,
        .skipSel, .stopOp, .haltOp, .cpuReady, .rcClockIn, .rxReady, .irqAck, .rxByte, .requestFlags,
        .masterIrqGate, .sourceEnableField, .shiftModeBits, .skipTaken, .cpuClockEn, .rcClockOut, .standbyStop,
        .standbyHalt);
    serial_peer_model peer (.serialClkN, .serialIn, .serialOut);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic op(input logic [6:0] v, input logic [3:0] a);
        @(posedge clk);
        ops <= v;
        arg <= a;
        @(posedge clk);
        ops <= 7'h0;
        #1;
    endtask
    // event pins held long enough to cross the synchroniser
    task automatic ev(input logic [2:0] p);
        @(posedge clk);
        pins <= p;
        repeat (6) @(posedge clk);
        pins <= 3'h0;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic waitAck(input logic [7:0] vec);
        for (int i = 0; i < 10 && irqAck.valid !== 1'b1; i++)
            @(posedge clk) #1;
        check({irqAck.valid, irqAck.vector}, {1'b1, vec});
    endtask
    task automatic pop;
        @(posedge clk);
        rxReady <= 1'b1;
        @(posedge clk);
        rxReady <= 1'b0;
        #1;
    endtask
    task automatic testDone;
        $display("checks %0d miscompares %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // clock and free-running rc source
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) rcClockIn <= ~rcClockIn;
    // a hang ends the run
    initial
    begin
        #200000;
        miscompares++;
        testDone;
    end
    // main sequence
    initial
    begin
        {nrst, pins, ops, arg, rcClockIn, rxReady} = '0;
        cpuReady = 1'b1;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        #1;
        check({requestFlags, masterIrqGate, sourceEnableField, shiftModeBits, serialOut, irqAck.valid}, 16'h2);
        ev(3'h5);
        op(OPEN, 4'h0);
        repeat (3) @(posedge clk) #1;
        check({requestFlags, masterIrqGate}, 16'hB);
        op(WE, 4'h7);
        waitAck(VEC_TIMER);
        check({requestFlags, masterIrqGate, sourceEnableField}, 16'h47);
        op(OPEN, 4'h0);
        waitAck(VEC_EXT_ONE);
        op(WM | OPEN, 4'h1);
        op(CLOSE, 4'h0);
        ev(3'h2);
        check({requestFlags, masterIrqGate}, 16'h4);
        op(OPEN, 4'h0);
        waitAck(VEC_SHARED);
        op(WM, 4'h8);
        peer.xfer(8'hA5, rx);
        peer.xfer(8'h3C, rx);
        repeat (6) @(posedge clk) #1;
        check(rx, 8'hA5);
        check({requestFlags, rxByte}, 16'h5A5);
        pop;
        check(rxByte, 9'h13C);
        pop;
        check(rxByte.valid, 1'b0);
        op(STOP, 4'h0);
        check({standbyStop, standbyHalt}, 2'h0);
        op(SKIP, 4'h1);
        check({skipTaken, requestFlags}, 4'h8);
        op(STOP, 4'h0);
        check(standbyStop, 1'b1);
        ev(3'h4);
        check({standbyStop, cpuClockEn, rcClockOut}, 3'h4);
        op(SKIP, 4'h2);
        ev(3'h1);
        check(standbyStop, 1'b0);
        op(SKIP, 4'h0);
        op(HALT, 4'h0);
        check(standbyHalt, 1'b1);
        ev(3'h4);
        check(standbyHalt, 1'b0);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk) #1;
        check({requestFlags, sourceEnableField, shiftModeBits, standbyHalt}, 16'h0);
        testDone;
    end
endmodule

bind irq_standby_serial_unit irq_standby_serial_unit_asserts chk (.clk, .nrst, .gateOpenOp, .gateCloseOp, .stopOp,
    .haltOp, .cpuReady, .irqAck, .requestFlags, .masterIrqGate, .sourceEnableField, .standbyStop, .standbyHalt,
    .cpuClockEn, .rcClockOut);
